// file: verilog/leh_pkg.sv
// Constants and types for the linear encoder homing block.
// Assumes a single 125 MHz clock with synchronous active-low reset.
// Notes on behaviour
// - Incremental: reference points every interval from the first mark.
// - The interval is set by the third select digit.
// - Dog homing takes the next reference point after the dog releases.
// - No mark ahead ends homing in error; jog to the far end to retry.
// - The encoder index pulse is never a homing reference.
// - Absolute: reference points at the same interval from position zero.
// - Data-set homing adopts the current position as home.
// - An overload, overvoltage or overload warning ends a pole test run.
// - Two pole words are read and written; writes apply after power cycle.
package leh_pkg;
  localparam int          LEH_POS_W       = 32;
  localparam int          LEH_POLE_W      = 16;
  localparam int          LEH_SEL_W       = 4;
  // Log2 of the default interval of 1048576 pulses.
  localparam int          LEH_INTV_LOG2   = 20;
  localparam logic [3:0]  LEH_SEL_RST     = 4'h0;
  localparam logic [15:0] LEH_POLE_RST    = 16'h0000;
  localparam logic [31:0] LEH_POS_RST     = 32'h0000_0000;

  typedef enum logic [1:0] {
    LEH_MODE_DOG,
    LEH_MODE_DATASET,
    LEH_MODE_NONE
  } leh_mode_t;

  typedef enum {
    LEH_IDLE,
    LEH_SEEK_MARK,
    LEH_WAIT_DOG,
    LEH_SEEK_REF,
    LEH_DONE
  } leh_state_t;
endpackage : leh_pkg

// file: verilog/leh_homing.sv
// Home position reference logic for a linear servo axis.
// Assumes encoder count, mark, dog and alarm inputs arrive from pins and are
// synchronised here; the command inputs come from logic on the same clock.
`timescale 1ns/1ps
module leh_homing #(
  parameter int POS_W = 32
) (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Commands from the controller side.
  input  wire logic                          home_start,
  input  wire leh_pkg::leh_mode_t            home_mode,
  input  wire logic                          abs_encoder,
  input  wire logic [leh_pkg::LEH_SEL_W-1:0] linear_function_select,
  input  wire logic [POS_W-1:0]              home_coord,
  // Encoder and machine pins.
  input  wire logic [POS_W-1:0]              enc_pos,
  input  wire logic                          ref_mark,
  input  wire logic                          mark_absent,
  input  wire logic                          prox_dog,
  input  wire logic                          encoder_index_pulse,
  // Pole detection test run.
  input  wire logic                          pole_test_start,
  input  wire logic [4:0]                    alarm_in,
  // Pole data words.
  input  wire logic                          pole_wr,
  input  wire logic                          pole_sel,
  input  wire logic [leh_pkg::LEH_POLE_W-1:0] pole_wdata,
  // Results.
  output logic [POS_W-1:0]                   pos_q,
  output logic                               home_done_q,
  output logic                               home_err_q,
  output logic                               pole_test_run_q,
  output logic [leh_pkg::LEH_POLE_W-1:0]     pole_rdata_q,
  output logic [leh_pkg::LEH_POLE_W-1:0]     pole_act1_q,
  output logic [leh_pkg::LEH_POLE_W-1:0]     pole_act2_q
);
  import leh_pkg::*;

  // Refuse counters too narrow for the widest reference interval.
  if (POS_W < LEH_INTV_LOG2 + 8) begin : g_pos_w_check
    $error("POS_W too small for interval");
  end

  // Two-stage synchronisers for pin inputs.
  logic [POS_W-1:0] pos_s1_q, pos_s2_q;
  logic [7:0]       pin_s1_q, pin_s2_q;
  logic             mark_prev_q, dog_prev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_s1_q <= '0;
      pos_s2_q <= '0;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pos_s1_q <= enc_pos;
      pos_s2_q <= pos_s1_q;
      pin_s1_q <= {ref_mark, mark_absent, prox_dog, alarm_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Synchronised pin views and edges; the index pulse is deliberately unused.
  wire       mark_w    = pin_s2_q[7];
  wire       absent_w  = pin_s2_q[6];
  wire       dog_w     = pin_s2_q[5];
  wire [4:0] alarm_w   = pin_s2_q[4:0];
  wire       mark_rise = mark_w & ~mark_prev_q;
  wire       dog_fall  = ~dog_w & dog_prev_q;
  wire       unused_w  = encoder_index_pulse;

  // Reference interval from the third digit: 2^(20 + digit), capped.
  wire [4:0] shift_w = 5'(LEH_INTV_LOG2) +
                       ((linear_function_select > 4'h7) ? 5'h7 :
                        5'(linear_function_select));
  wire [POS_W-1:0] mask_w = (POS_W'(1) << shift_w) - POS_W'(1);

  // Offset of the current position from the reference origin.
  logic [POS_W-1:0] origin_q;
  logic [POS_W-1:0] pos_prev_q;
  wire  [POS_W-1:0] rel_w   = pos_s2_q - origin_q;
  wire              on_ref  = (rel_w & mask_w) == '0;

  leh_state_t st_q, st_d;
  logic       done_d, err_d, load_d;

  // Homing sequencer.
  always_comb begin
    st_d   = st_q;
    done_d = 1'b0;
    err_d  = 1'b0;
    load_d = 1'b0;
    unique case (st_q)
      LEH_IDLE: begin
        if (home_start && home_mode == LEH_MODE_DATASET) begin
          load_d = 1'b1;
          st_d   = LEH_DONE;
        end else if (home_start && home_mode == LEH_MODE_DOG) begin
          st_d = abs_encoder ? LEH_WAIT_DOG : LEH_SEEK_MARK;
        end
      end
      LEH_SEEK_MARK: begin
        if (absent_w) begin
          err_d = 1'b1;
          st_d  = LEH_IDLE;
        end else if (mark_rise) begin
          st_d = LEH_WAIT_DOG;
        end
      end
      LEH_WAIT_DOG: begin
        if (dog_fall) st_d = LEH_SEEK_REF;
      end
      LEH_SEEK_REF: begin
        if (on_ref) begin
          load_d = 1'b1;
          st_d   = LEH_DONE;
        end
      end
      LEH_DONE: begin
        done_d = 1'b1;
        st_d   = LEH_IDLE;
      end
    endcase
  end

  // State, origin capture, position counter and completion flags.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q        <= LEH_IDLE;
      origin_q    <= '0;
      mark_prev_q <= 1'b0;
      dog_prev_q  <= 1'b0;
      pos_q       <= POS_W'(LEH_POS_RST);
      home_done_q <= 1'b0;
      home_err_q  <= 1'b0;
    end else begin
      st_q        <= st_d;
      mark_prev_q <= mark_w;
      dog_prev_q  <= dog_w;
      if (st_q == LEH_IDLE && home_start) begin
        origin_q <= '0;
      end else if (st_q == LEH_SEEK_MARK && mark_rise) begin
        origin_q <= pos_s2_q;
      end
      if (load_d) begin
        pos_q <= home_coord;
      end else begin
        pos_q <= pos_q + (pos_s2_q - pos_prev_q);
      end
      home_done_q <= done_d;
      home_err_q  <= err_d;
    end
  end

  // Homing checks: data-set load, mark capture, dog release and results.
  AST_DSET_LOAD: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == LEH_IDLE && home_start && home_mode == LEH_MODE_DATASET)
      |=> (pos_q == $past(home_coord)))
    else $error("data-set homing did not load the home coordinate");

  AST_ABS_ORIGIN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == LEH_IDLE && home_start && home_mode == LEH_MODE_DOG &&
     abs_encoder)
      |=> (origin_q == '0 && st_q == LEH_WAIT_DOG))
    else $error("absolute homing did not start from position zero");

  AST_MARK_ORIGIN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == LEH_SEEK_MARK && !absent_w && mark_rise)
      |=> (origin_q == $past(pos_s2_q) && st_q == LEH_WAIT_DOG))
    else $error("reference mark position was not captured");

  AST_NO_MARK_ERR: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == LEH_SEEK_MARK && absent_w)
      |=> (home_err_q && st_q == LEH_IDLE))
    else $error("missing mark did not end homing with an error");

  AST_DOG_REF: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == LEH_WAIT_DOG && dog_fall) |=> (st_q == LEH_SEEK_REF))
    else $error("dog release did not start the reference search");

  AST_REF_LOAD: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == LEH_SEEK_REF && on_ref)
      |=> (pos_q == $past(home_coord)) ##1 home_done_q)
    else $error("home reference did not load and report completion");

  AST_DONE_PULSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    home_done_q |=> !home_done_q)
    else $error("homing done held longer than one cycle");

  AST_ERR_EXCL: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(home_done_q && home_err_q))
    else $error("homing done and homing error raised together");

  // Main homing scenarios to be seen at least once.
  AST_COV_DSET: cover property (
    @(posedge clk) disable iff (!rst_n)
    st_q == LEH_IDLE && home_start && home_mode == LEH_MODE_DATASET);
  AST_COV_DOG_HOME: cover property (
    @(posedge clk) disable iff (!rst_n)
    st_q == LEH_SEEK_REF && on_ref);
  AST_COV_NO_MARK: cover property (
    @(posedge clk) disable iff (!rst_n)
    home_err_q);

  // Previous encoder sample for position tracking after homing.
  always_ff @(posedge clk) begin
    if (!rst_n) pos_prev_q <= '0;
    else pos_prev_q <= pos_s2_q;
  end

  // Pole detection test run ends on any protective alarm.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pole_test_run_q <= 1'b0;
    end else if (|alarm_w) begin
      pole_test_run_q <= 1'b0;
    end else if (pole_test_start) begin
      pole_test_run_q <= 1'b1;
    end
  end

  // An alarm must end the run at the very next edge.
  AST_ALARM_STOP: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|alarm_w) |=> !pole_test_run_q)
    else $error("protective alarm did not end the pole test run");
  AST_COV_ALARM: cover property (
    @(posedge clk) disable iff (!rst_n)
    pole_test_run_q ##1 !pole_test_run_q);

  // Stored pole words keep their value through reset, which stands for a
  // power cycle here, so a written word is not lost before it applies.
  logic [LEH_POLE_W-1:0] pole_st_q [2];
  always_ff @(posedge clk) begin
    if (pole_wr) begin
      pole_st_q[pole_sel] <= pole_wdata;
    end
  end

  // Read port follows the selected word; active copies load only in reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pole_rdata_q <= LEH_POLE_RST;
      pole_act1_q  <= pole_st_q[0];
      pole_act2_q  <= pole_st_q[1];
    end else begin
      pole_rdata_q <= pole_st_q[pole_sel];
    end
  end
endmodule : leh_homing

// file: verif/leh_enc_model.sv
// Encoder model for the homing block: ramps position, flags the mark.
// Assumes the bench loads a start position before each run.
`timescale 1ns/1ps
module leh_enc_model (
  // Clock and controls.
  input  wire logic        clk,
  input  wire logic        move,
  input  wire logic        ld,
  input  wire logic [31:0] ld_val,
  input  wire logic [31:0] mark_at,
  // Encoder pins.
  output logic [31:0]      pos,
  output logic             ref_mark,
  output logic             index
);
  // Position ramps by a fixed step so each pass crosses the mark once.
  always @(posedge clk) begin
    if (ld) pos <= ld_val;
    else if (move) pos <= pos + 32'h0000_1000;
  end
  // The mark is seen while the head lies within one step past it.
  assign ref_mark = (pos - mark_at) < 32'h0000_1000;
  // Index pulse toggles off the grid, so using it would misplace home.
  assign index = pos[13] ^ pos[16];
endmodule : leh_enc_model

// file: verif/tb_linear_encoder_homing.sv
// Self-checking bench for the homing block with an encoder model.
// Assumes a 125 MHz clock and an encoder model stepping once per clock.
`timescale 1ns/1ps
module tb_linear_encoder_homing;
  import leh_pkg::*;
  localparam logic [31:0] IV = 32'h0010_0000;
  logic clk = 0, rst_n = 0, home_start = 0, abs_encoder = 0, ld = 1;
  logic mark_absent = 0, prox_dog = 0, pole_test_start = 0, move = 0;
  logic pole_wr = 0, pole_sel = 0, ref_mark, idx, done, err, run;
  leh_mode_t home_mode = LEH_MODE_DOG;
  logic [3:0]  lfs = LEH_SEL_RST;
  logic [31:0] home_coord = 0, ld_val = 0, mark_at = 0, lf = 32'd37;
  logic [31:0] enc_pos, pos, p0, r, rf, iv;
  logic [4:0]  alarm_in = 0;
  logic [15:0] pole_wdata = 0, rd, a1, a2, s1, s2, w1, w2;
  int failures = 0, cmp_count = 0, cyc = 0, n, k;
  // Clock generation.
  always #4 clk = ~clk;
  leh_enc_model enc (.clk(clk), .move(move), .ld(ld), .ld_val(ld_val),
    .mark_at(mark_at), .pos(enc_pos), .ref_mark(ref_mark), .index(idx));
  leh_homing dut (.clk(clk), .rst_n(rst_n), .home_start(home_start),
    .home_mode(home_mode), .abs_encoder(abs_encoder),
    .linear_function_select(lfs), .home_coord(home_coord),
    .enc_pos(enc_pos), .ref_mark(ref_mark), .mark_absent(mark_absent),
    .prox_dog(prox_dog), .encoder_index_pulse(idx),
    .pole_test_start(pole_test_start), .alarm_in(alarm_in),
    .pole_wr(pole_wr), .pole_sel(pole_sel), .pole_wdata(pole_wdata),
    .pos_q(pos), .home_done_q(done), .home_err_q(err),
    .pole_test_run_q(run), .pole_rdata_q(rd), .pole_act1_q(a1),
    .pole_act2_q(a2));
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // Expected reference spacing for a select digit.
  function logic [31:0] intv(input logic [3:0] s);
    return IV << s;
  endfunction : intv
  task wt(input int c);
    repeat (c) @(negedge clk);
  endtask : wt
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task close_out;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task rs;
    rst_n = 0;
    wt(2);
    rst_n = 1;
  endtask : rs
  task go;
    home_start = 1;
    wt(1);
    home_start = 0;
  endtask : go
  // Dog homing from a random start; home is the next grid point.
  // Start sits on the step grid, well clear of any reference point.
  task dog(input logic ab, input logic [3:0] sel);
    lf = lfsr(lf);
    p0 = {4'h0, lf[27:20], 20'h10000};
    lf = lfsr(lf);
    home_coord = lf;
    mark_at = p0 + 32'h4000;
    ld_val = p0;
    ld = 1;
    abs_encoder = ab;
    lfs = sel;
    iv = intv(sel);
    prox_dog = 1;
    home_mode = LEH_MODE_DOG;
    wt(2);
    ld = 0;
    move = 1;
    go;
    wt(12);
    prox_dog = 0;
    r = enc_pos - (ab ? 32'h0 : mark_at);
    rf = (ab ? 32'h0 : mark_at) + (r / iv + 1) * iv;
    for (n = 0; n < 1200 && done !== 1'b1 && err !== 1'b1; n++) wt(1);
    chk(done === 1'b1 && err === 1'b0, "dog homing stuck");
    move = 0;
    wt(4);
    chk(enc_pos - rf < 32'h8000, "home off reference grid");
    chk(pos === home_coord + enc_pos - rf, "home not loaded");
    $display("test dog homing abs=%0d sel=%0d ended", ab, sel);
    rs;
  endtask : dog
  // Timeout guard.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    rs;
    ld = 0;
    for (k = 0; k < 3; k++) begin
      lf = lfsr(lf);
      home_coord = lf;
      home_mode = LEH_MODE_DATASET;
      go;
      for (n = 0; n < 50 && done !== 1'b1; n++) wt(1);
      chk(done === 1'b1 && pos === home_coord, "data set homing");
      rs;
    end
    $display("test data set ended");
    dog(1'b0, 4'h0);
    dog(1'b1, 4'h0);
    dog(1'b0, 4'h1);
    abs_encoder = 0;
    mark_absent = 1;
    home_mode = LEH_MODE_DOG;
    prox_dog = 1;
    go;
    for (n = 0; n < 50 && err !== 1'b1; n++) wt(1);
    chk(err === 1'b1 && done === 1'b0, "no homing error");
    mark_absent = 0;
    prox_dog = 0;
    rs;
    $display("test missing mark ended");
    for (k = 0; k < 5; k++) begin
      pole_test_start = 1;
      wt(1);
      pole_test_start = 0;
      wt(3);
      chk(run === 1'b1, "pole test not running");
      alarm_in = 5'h01 << k;
      for (n = 0; n < 20 && run !== 1'b0; n++) wt(1);
      chk(run === 1'b0, "alarm did not end test run");
      alarm_in = 0;
      wt(2);
    end
    $display("test pole alarms ended");
    s1 = a1;
    s2 = a2;
    for (k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      pole_sel = k[0];
      pole_wdata = lf[15:0];
      if (k == 0) w1 = pole_wdata;
      else w2 = pole_wdata;
      pole_wr = 1;
      wt(1);
      pole_wr = 0;
      wt(2);
      chk(rd === pole_wdata, "pole word readback");
      chk(a1 === s1 && a2 === s2, "pole word active too early");
    end
    rs;
    wt(1);
    chk(a1 === w1 && a2 === w2 && rd === w2, "pole words lost");
    $display("test pole data ended");
    close_out;
  end
endmodule : tb_linear_encoder_homing
